// File: vector_trap_and_subset_control_tb_top.sv
// bench for the vector trap and subset control block
`include "vtsc_defs.vh"
`default_nettype none
module vector_trap_and_subset_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, wbCyc = 0, wbStb = 0, wbWe = 0, decValid = 0;
  logic elemValid = 0, elemIsStore = 0, elemNonIdem = 0, trapReq = 0;
  logic elemRestartSafe = 1, trapIsIntr = 0, wbAck, irq, decIllegal;
  logic elemCommitEn, trapTaken, youngerFlush, singleStep, olderCommitted;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'hf, lag = 4'ha;
  logic [31:0] wbDatW = 32'h0, trapPc = 32'h0, wbDatR, epcOut, rd;
  logic [1:0] decEw = 2'h0;
  logic [2:0] decOp = 3'h0;
  logic [15:0] elemIdx = 16'h0, trapIdx = 16'h0, restartIdx;
  int errorCnt = 0, checksDone = 0;
  always #25 mclk = ~mclk;
  vtsc_vector_trap_ctrl dut_u (.*);
  vtsc_pipe_model pm_u (.*);
  task automatic chk(input logic [31:0] got, exp);
    checksDone++;
    if (got !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, logic [31:0] d);
    @(posedge mclk);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatW} <= {2'h3, we, a, d};
    do @(posedge mclk); while (wbAck !== 1'b1);
    rd = wbDatR;
    {wbCyc, wbStb} <= 2'h0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic dec(input logic [1:0] ew, input logic [2:0] op, logic e);
    @(posedge mclk);
    {decValid, decEw, decOp} <= {1'b1, ew, op};
    @(posedge mclk);
    decValid <= 0;
    #1 chk(decIllegal, e);
  endtask
  task automatic elem(input logic [15:0] i, input logic [3:0] k);
    @(posedge mclk);
    {elemValid, elemIdx, elemIsStore, elemNonIdem, elemRestartSafe} <=
      {1'b1, i, k[3:1]};
    @(posedge mclk);
    elemValid <= 0;
    #1 chk(elemCommitEn, k[0]);
  endtask
  task automatic trap(input logic [31:0] pc, input logic [15:0] ix);
    @(posedge mclk);
    {trapReq, trapPc, trapIdx} <= {1'b1, pc, ix};
    trapIsIntr <= ~trapIsIntr;
    @(posedge mclk);
    trapReq <= 0;
  endtask
  task automatic take(input logic [31:0] pc, input logic [15:0] ix);
    do @(posedge mclk); while (trapTaken !== 1'b1);
    chk(epcOut, pc);
    chk(restartIdx, ix);
  endtask
  // fp ops at 8/16 bits and widening ops at 64 are left unjudged
  function automatic logic ill(int s, logic x, int e, int o);
    if (e == 3 && s < 2) return 1;
    case (o)
      0: return 0;
      3: return e == 3;
      5: return e == 3 && !x;
      2, 7: return s != 4;
      default: return e == 2 ? !(s == 1 || s >= 3) : s != 4;
    endcase
  endfunction
  task giveVerdict;
    $display("checks %0d errors %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge mclk);
    errorCnt++;
    giveVerdict;
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 0;
    rdc(`VTSC_ADDR_CAPS, 32'h183);
    wb(1, `VTSC_ADDR_CFG, 32'h1a4);
    rdc(`VTSC_ADDR_CAPS, 32'h2bf);
    wb(1, `VTSC_ADDR_CFG, 32'h050);
    rdc(`VTSC_ADDR_CAPS, 32'h141);
    rdc(8'h1c, 32'h0);
    for (int s = 0; s < 5; s++)
      for (int x = 0; x < 2; x++) begin
        wb(1, `VTSC_ADDR_CFG, {23'h0, x[0], 5'hc, s[2:0]});
        for (int o = 0; o < 8; o++)
          for (int e = 0; e < 4; e++)
            if (o inside {0, 3, 5} || e == 2 ||
                (e == 3 && o inside {1, 4, 6}))
              dec(e[1:0], o[2:0], ill(s, x[0], e, o));
      end
    wb(1, `VTSC_ADDR_STATUS, 32'h7);
    wb(1, `VTSC_ADDR_MASK, 32'h1);
    trap(32'h1230, 16'h5);
    elem(16'h4, 4'hd);
    elem(16'h5, 4'he);
    elem(16'h9, 4'h0);
    elem(16'h9, 4'h3);
    take(32'h1230, 16'h5);
    @(posedge mclk);
    #1 chk(irq, 1'b1);
    rdc(`VTSC_ADDR_EPC, 32'h1230);
    rdc(`VTSC_ADDR_RSTIDX, 32'h5);
    rdc(`VTSC_ADDR_STATUS, 32'h1);
    wb(1, `VTSC_ADDR_STATUS, 32'h1);
    rdc(`VTSC_ADDR_STATUS, 32'h0);
    #1 chk(irq, 1'b0);
    lag <= 4'h1;
    repeat (5) begin
      trap(32'h2000, 16'h7);
      take(32'h2000, 16'h7);
    end
    #1 chk(singleStep, 1'b1);
    elem(16'h7, 4'h3);
    @(posedge mclk);
    #1 chk(singleStep, 1'b0);
    giveVerdict;
  end
endmodule // vector_trap_and_subset_control_tb_top
`default_nettype wire

// File: vtsc_defs.vh
// constants for the vector trap and subset control block
`ifndef VTSC_DEFS_VH
`define VTSC_DEFS_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define VTSC_ADDR_CFG 8'h00
`define VTSC_ADDR_STATUS 8'h04
`define VTSC_ADDR_MASK 8'h08
`define VTSC_ADDR_EPC 8'h0c
`define VTSC_ADDR_RSTIDX 8'h10
`define VTSC_ADDR_CAPS 8'h14
`define VTSC_ADDR_PROGRESS 8'h18
// ---------------------------------------------------------------
// configuration fields
// ---------------------------------------------------------------
`define VTSC_CFG_SUB_LSB 0
`define VTSC_CFG_SUB_MSB 2
`define VTSC_CFG_VLOG_LSB 4
`define VTSC_CFG_VLOG_MSB 7
`define VTSC_CFG_XLEN64 8
`define VTSC_CFG_RESET 32'h0000_0102
// subset codes
`define VTSC_SUB_I32 3'h0
`define VTSC_SUB_SP32 3'h1
`define VTSC_SUB_I64 3'h2
`define VTSC_SUB_SP64 3'h3
`define VTSC_SUB_DP64 3'h4
// minimum length guarantees, as log2 of bits
`define VTSC_VLOG_MIN 4'h5
`define VTSC_VLOG_MAX 4'ha
// ---------------------------------------------------------------
// status / mask bits
// ---------------------------------------------------------------
`define VTSC_ST_TRAP 0
`define VTSC_ST_ILL 1
`define VTSC_ST_STALL 2
`define VTSC_ST_W 3
// ---------------------------------------------------------------
// element width codes and op classes
// ---------------------------------------------------------------
`define VTSC_EW8 2'h0
`define VTSC_EW16 2'h1
`define VTSC_EW32 2'h2
`define VTSC_EW64 2'h3
`define VTSC_OP_INT 3'h0
`define VTSC_OP_FP 3'h1
`define VTSC_OP_FPWIDE 3'h2
`define VTSC_OP_SMUL 3'h3
`define VTSC_OP_PERMFP 3'h4
`define VTSC_OP_IDX 3'h5
`define VTSC_OP_FPRED 3'h6
`define VTSC_OP_FPWRED 3'h7
// repeated traps at one index before forcing a single-element step
`define VTSC_RETRY_LIMIT 4'h3
`endif

// File: vtsc_pipe_model.sv
// scalar pipeline stand-in: older work drains some cycles into a flush
`default_nettype none
module vtsc_pipe_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic youngerFlush,
  input wire logic [3:0] lag,
  output logic olderCommitted
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] drainCnt_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst || !youngerFlush) drainCnt_q <= 4'h0;
    else if (drainCnt_q != 4'hf) drainCnt_q <= drainCnt_q + 4'h1;
  end
  // long lag keeps the trap pending so commits can be probed
  assign olderCommitted = youngerFlush && drainCnt_q >= lag;
endmodule // vtsc_pipe_model
`default_nettype wire

// File: vtsc_trap_sva.sv
// assertions on the trap, element commit and decode check ports
`default_nettype none
module vtsc_trap_sva #(parameter AW = 32, parameter IW = 16) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic decValid,
  input wire logic decIllegal,
  input wire logic elemValid,
  input wire logic [IW-1:0] elemIdx,
  input wire logic elemIsStore,
  input wire logic elemNonIdem,
  input wire logic elemRestartSafe,
  input wire logic elemCommitEn,
  input wire logic trapReq,
  input wire logic [AW-1:0] trapPc,
  input wire logic [IW-1:0] trapIdx,
  input wire logic olderCommitted,
  input wire logic trapTaken,
  input wire logic youngerFlush,
  input wire logic [AW-1:0] epcOut,
  input wire logic [IW-1:0] restartIdx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [AW-1:0] capPc_q;
  logic [IW-1:0] capIdx_q;
  // a request is only taken when none is pending; the flush flag tracks
  // the pending state, so a request in the take cycle is ignored too
  wire accept = trapReq && !youngerFlush;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      capPc_q <= '0;
      capIdx_q <= '0;
    end else if (accept) begin
      capPc_q <= trapPc;
      capIdx_q <= trapIdx;
    end
  end
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  epc_load_a: assert property (trapTaken |->
    epcOut == capPc_q && restartIdx == capIdx_q) else $error("bad epc");
  idx_hold_a: assert property ($changed(restartIdx) |-> trapTaken)
    else $error("restart index moved");
  older_first_a: assert property (trapTaken |-> $past(olderCommitted))
    else $error("trap before older commit");
  take_bound_a: assert property (youngerFlush && olderCommitted |=>
    trapTaken) else $error("trap late");
  flush_start_a: assert property (accept |=> youngerFlush)
    else $error("no flush");
  flush_end_a: assert property ($fell(youngerFlush) |-> trapTaken)
    else $error("flush ended early");
  below_commit_a: assert property (youngerFlush && elemValid &&
    elemIdx < capIdx_q |=> elemCommitEn) else $error("low elem blocked");
  unsafe_block_a: assert property (youngerFlush && elemValid &&
    !elemRestartSafe && elemIdx >= capIdx_q |=> !elemCommitEn)
    else $error("unsafe elem committed");
  nonidem_block_a: assert property (youngerFlush && elemValid &&
    elemIsStore && elemNonIdem && elemIdx >= capIdx_q |=> !elemCommitEn)
    else $error("store committed");
  illegal_cause_a: assert property (decIllegal |-> $past(decValid))
    else $error("stray illegal");
  cover property (trapTaken);
  cover property (decIllegal);
  cover property (youngerFlush && elemValid && elemNonIdem);
endmodule // vtsc_trap_sva
bind vtsc_vector_trap_ctrl vtsc_trap_sva #(.AW(AW), .IW(IW)) sva_u (.*);
`default_nettype wire

// File: vtsc_vector_trap_ctrl.v
// trap reporting, commit ordering and subset checking for the vector unit
//
// Contract
// - trap writes instruction address and element index
// - older instructions commit before trap taken
// - younger instructions never modify state on trap
// - elements below restart index all committed
// - later elements untouched unless safely re-executable
// - no non-idempotent store at or past fault
// - repeated traps force progress on reported element
// - imprecise synchronous traps still report faulting element
// - all standard subsets deliver precise traps only
// - minimum length power of two, 32..1024
// - advertise every shorter length guarantee too
// - widths 8/16/32, 64 on 64-bit subsets
// - subsets usable with 32 or 64 scalar width
// - reject 64-bit indices when scalar width 32
// - no 64-bit fractional saturating multiply on 64 subsets
// - drop fp permutes per integer/sp64 subset
// - single-precision subsets do 32-bit fp ops
// - double subset does 32/64 fp and widening
//
// Design decisions made here: the register offsets and the Wishbone register port.
`include "vtsc_defs.vh"
`default_nettype none
module vtsc_vector_trap_ctrl #(
  parameter AW = 32,
  parameter IW = 16
) (
  input wire mclk,
  input wire rst,
  // classic wishbone slave
  input wire wbCyc,
  input wire wbStb,
  input wire wbWe,
  input wire [7:0] wbAdr,
  input wire [3:0] wbSel,
  input wire [31:0] wbDatW,
  output reg [31:0] wbDatR,
  output reg wbAck,
  output reg irq,
  // decode check
  input wire decValid,
  input wire [1:0] decEw,
  input wire [2:0] decOp,
  output reg decIllegal,
  // element execution from the vector pipe
  input wire elemValid,
  input wire [IW-1:0] elemIdx,
  input wire elemIsStore,
  input wire elemNonIdem,
  input wire elemRestartSafe,
  output reg elemCommitEn,
  // trap requests
  input wire trapReq,
  input wire trapIsIntr,
  input wire [AW-1:0] trapPc,
  input wire [IW-1:0] trapIdx,
  input wire olderCommitted,
  output reg trapTaken,
  output reg youngerFlush,
  output reg [AW-1:0] epcOut,
  output reg [IW-1:0] restartIdx,
  output reg singleStep
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [31:0] cfgQ;
  reg [`VTSC_ST_W-1:0] statusQ;
  reg [`VTSC_ST_W-1:0] maskQ;
  reg [3:0] retryQ;
  reg [IW-1:0] lastIdxQ;
  reg trapPendQ;
  reg [AW-1:0] pendPcQ;
  reg [IW-1:0] pendIdxQ;

  wire [2:0] subset = cfgQ[`VTSC_CFG_SUB_MSB:`VTSC_CFG_SUB_LSB];
  wire [3:0] vlogRaw = cfgQ[`VTSC_CFG_VLOG_MSB:`VTSC_CFG_VLOG_LSB];
  wire xlen64 = cfgQ[`VTSC_CFG_XLEN64];

  // ---------------------------------------------------------------
  // subset decode
  // ---------------------------------------------------------------
  function is64sub;
    input [2:0] s;
    begin
      is64sub = (s == `VTSC_SUB_I64) || (s == `VTSC_SUB_SP64) ||
        (s == `VTSC_SUB_DP64);
    end
  endfunction

  function hasFp32;
    input [2:0] s;
    begin
      hasFp32 = (s == `VTSC_SUB_SP32) || (s == `VTSC_SUB_SP64) ||
        (s == `VTSC_SUB_DP64);
    end
  endfunction

  // floor of the length guarantee for the chosen subset
  wire [3:0] vlogFloor = is64sub(subset) ? 4'h6 : `VTSC_VLOG_MIN;
  // clamp into the legal power-of-two range
  wire [3:0] vlogEff = (vlogRaw < vlogFloor) ? vlogFloor :
    (vlogRaw > `VTSC_VLOG_MAX) ? `VTSC_VLOG_MAX : vlogRaw;

  // every shorter guarantee is also advertised
  wire [5:0] capLen;
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : gCap
      assign capLen[g] = (vlogEff >= (`VTSC_VLOG_MIN + g));
    end
  endgenerate

  // legality of one decoded op against the subset
  reg illegalC;
  always @* begin
    illegalC = 1'b0;
    if (decEw == `VTSC_EW64 && !is64sub(subset))
      illegalC = 1'b1;
    case (decOp)
      `VTSC_OP_INT: ;
      `VTSC_OP_IDX: begin
        if (decEw == `VTSC_EW64 && !xlen64)
          illegalC = 1'b1;
      end
      `VTSC_OP_SMUL: begin
        if (decEw == `VTSC_EW64)
          illegalC = 1'b1;
      end
      `VTSC_OP_PERMFP: begin
        if (!hasFp32(subset))
          illegalC = 1'b1;
        else if (decEw == `VTSC_EW64 && subset != `VTSC_SUB_DP64)
          illegalC = 1'b1;
        else if (decEw != `VTSC_EW64 && decEw != `VTSC_EW32)
          illegalC = 1'b1;
      end
      `VTSC_OP_FP, `VTSC_OP_FPRED: begin
        if (!hasFp32(subset) || decEw == `VTSC_EW8 || decEw == `VTSC_EW16)
          illegalC = 1'b1;
        else if (decEw == `VTSC_EW64 && subset != `VTSC_SUB_DP64)
          illegalC = 1'b1;
      end
      `VTSC_OP_FPWIDE, `VTSC_OP_FPWRED: begin
        // only fp32 to fp64 widening exists, and only in the double subset
        if (subset != `VTSC_SUB_DP64 || decEw != `VTSC_EW32)
          illegalC = 1'b1;
      end
      default: illegalC = 1'b1;
    endcase
  end

  // ---------------------------------------------------------------
  // element commit gating
  // ---------------------------------------------------------------
  // once a trap is pending, elements at or past its index are held unless restart-safe;
  // a non-idempotent store there must never reach memory
  wire atOrPast = trapPendQ && (elemIdx >= pendIdxQ);
  wire blockElem = atOrPast &&
    ((elemIsStore && elemNonIdem) || !elemRestartSafe);
  wire elemOk = elemValid && !blockElem;

  // the trap is taken only once older work has drained; precise only
  wire takeNow = trapPendQ && olderCommitted;

  // ---------------------------------------------------------------
  // trap sequencing
  // ---------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      trapPendQ <= 1'b0;
      pendPcQ <= {AW{1'b0}};
      pendIdxQ <= {IW{1'b0}};
      trapTaken <= 1'b0;
      youngerFlush <= 1'b0;
      epcOut <= {AW{1'b0}};
      restartIdx <= {IW{1'b0}};
      elemCommitEn <= 1'b0;
      decIllegal <= 1'b0;
      retryQ <= 4'h0;
      lastIdxQ <= {IW{1'b0}};
      singleStep <= 1'b0;
    end else begin
      trapTaken <= 1'b0;
      elemCommitEn <= elemOk;
      decIllegal <= decValid && illegalC;
      if (trapReq && !trapPendQ) begin
        trapPendQ <= 1'b1;
        pendPcQ <= trapPc;
        pendIdxQ <= trapIdx;
        youngerFlush <= 1'b1;
      end
      if (takeNow) begin
        trapPendQ <= 1'b0;
        trapTaken <= 1'b1;
        youngerFlush <= 1'b0;
        epcOut <= pendPcQ;
        restartIdx <= pendIdxQ;
        // count traps that hit the same element again
        if (pendIdxQ == lastIdxQ && retryQ != 4'hf)
          retryQ <= retryQ + 4'h1;
        else if (pendIdxQ != lastIdxQ)
          retryQ <= 4'h0;
        lastIdxQ <= pendIdxQ;
        if (pendIdxQ == lastIdxQ && retryQ >= `VTSC_RETRY_LIMIT)
          singleStep <= 1'b1;
      end
      // released once the reported element commits
      if (singleStep && elemOk && elemIdx == lastIdxQ) begin
        singleStep <= 1'b0;
        retryQ <= 4'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // wishbone slave and interrupt
  // ---------------------------------------------------------------
  wire acc = wbCyc && wbStb && !wbAck;
  wire wr = acc && wbWe;
  wire stallEvt = takeNow && pendIdxQ == lastIdxQ &&
    retryQ >= `VTSC_RETRY_LIMIT;
  wire [`VTSC_ST_W-1:0] evt = {stallEvt, decValid && illegalC, takeNow};
  wire [`VTSC_ST_W-1:0] clr = (wr && wbAdr == `VTSC_ADDR_STATUS && wbSel[0])
    ? wbDatW[`VTSC_ST_W-1:0] : {`VTSC_ST_W{1'b0}};

  reg [31:0] rdC;
  always @* begin
    case (wbAdr)
      `VTSC_ADDR_CFG: rdC = cfgQ;
      `VTSC_ADDR_STATUS: rdC = {{(32-`VTSC_ST_W){1'b0}}, statusQ};
      `VTSC_ADDR_MASK: rdC = {{(32-`VTSC_ST_W){1'b0}}, maskQ};
      `VTSC_ADDR_EPC: rdC = {{(32-AW){1'b0}}, epcOut};
      `VTSC_ADDR_RSTIDX: rdC = {{(32-IW){1'b0}}, restartIdx};
      `VTSC_ADDR_CAPS: rdC = {22'h0, vlogEff, capLen};
      `VTSC_ADDR_PROGRESS: rdC = {27'h0, singleStep, retryQ};
      default: rdC = 32'h0000_0000;
    endcase
  end

  integer b;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfgQ <= `VTSC_CFG_RESET;
      statusQ <= {`VTSC_ST_W{1'b0}};
      maskQ <= {`VTSC_ST_W{1'b0}};
      wbAck <= 1'b0;
      wbDatR <= 32'h0000_0000;
      irq <= 1'b0;
    end else begin
      wbAck <= acc;
      if (acc)
        wbDatR <= wbWe ? 32'h0000_0000 : rdC;
      if (wr && wbAdr == `VTSC_ADDR_CFG) begin
        for (b = 0; b < 4; b = b + 1) begin
          if (wbSel[b])
            cfgQ[b*8 +: 8] <= wbDatW[b*8 +: 8];
        end
      end
      if (wr && wbAdr == `VTSC_ADDR_MASK && wbSel[0])
        maskQ <= wbDatW[`VTSC_ST_W-1:0];
      // a new event wins over a simultaneous clear
      statusQ <= (statusQ & ~clr) | evt;
      irq <= |(((statusQ & ~clr) | evt) & maskQ);
    end
  end
endmodule // vtsc_vector_trap_ctrl
`default_nettype wire
